/* File: core/single_wire_reset_and_bit_slot.sv */
// Module: reset/presence and single time slot engine with register port
`timescale 1ns/1ps

// Contract
// - Reset command code starts a reset and presence-detect cycle on the line.
// - Reset cycle samples line at short-check and presence instants, reports both flags.
// - Busy lasts reset low plus high; flags update at low plus sample times.
// - Reset code arriving while busy is not acknowledged and is discarded.
// - Reset line activity starts within 262.5 ns of code acceptance.
// - Reset completes within reset low plus high time plus 262.5 ns.
// - Slot command takes a parameter; value 0 writes zero, 1 writes one/reads.
// - Both slot kinds sample the line at bit-sample time into the result flag.
// - Slot code arriving while busy: neither code nor parameter is acknowledged.
// - Slot line activity starts within 262.5 ns of the parameter arriving.
// - Slot command completes within one slot time plus 262.5 ns.
// - Busy stays high for one slot time; search branch flag may change.
// - Accepting a slot command points the read pointer at the status register.
// - Only parameter bit 7 carries the slot value; other bits ignored.
module single_wire_reset_and_bit_slot #(
  parameter int unsigned RST_LOW_CYC  = swl_pkg::ns_to_cyc(swl_pkg::RESET_LOW_TIME_NS),
  parameter int unsigned RST_HIGH_CYC = swl_pkg::ns_to_cyc(swl_pkg::RESET_HIGH_TIME_NS),
  parameter int unsigned CNT_W        = 16
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  input  wire logic [swl_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [31:0]                o_rdata,
  output logic                            o_cmd_ack,
  output logic                            o_cmd_nack,
  output logic                            o_irq,
  output swl_pkg::status_t                o_status,
  input  wire logic                       i_line,
  output logic                            o_line_o,
  output logic                            o_line_oe
);
  import swl_pkg::*;

  // ----------------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] C_RST_LOW  = CNT_W'(RST_LOW_CYC);
  localparam logic [CNT_W-1:0] C_RST_END  = CNT_W'(RST_LOW_CYC + RST_HIGH_CYC);
  localparam logic [CNT_W-1:0] C_PRES     = CNT_W'(RST_LOW_CYC + ns_to_cyc(PRESENCE_SAMPLE_NS));
  localparam logic [CNT_W-1:0] C_SHORT    = CNT_W'(RST_LOW_CYC + ns_to_cyc(SHORT_CHECK_TIME_NS));
  localparam logic [CNT_W-1:0] C_SLOT     = CNT_W'(ns_to_cyc(SLOT_TIME_NS));
  localparam logic [CNT_W-1:0] C_SAMPLE   = CNT_W'(ns_to_cyc(BIT_SAMPLE_TIME_NS));
  localparam logic [CNT_W-1:0] C_W0_LOW   = CNT_W'(ns_to_cyc(WRITE0_LOW_TIME_NS));
  localparam logic [CNT_W-1:0] C_W1_LOW   = CNT_W'(ns_to_cyc(WRITE1_LOW_TIME_NS));
  localparam logic [CNT_W-1:0] C_ONE      = CNT_W'(1);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t           state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             slot_val_q;
  logic             slot_pend_q;
  status_t          stat_q;
  events_t          irq_stat_q;
  events_t          irq_en_q;
  logic [1:0]       ptr_q;
  logic [2:0]       sync_q;
  logic             line_q;
  logic             busy;
  logic             wr_cmd;
  logic             wr_par;
  logic             start_rst;
  logic             start_slot;
  logic             finish;
  events_t          ev;

  assign busy = (state_q != ST_IDLE);
  assign wr_cmd = i_wr && hit(i_addr, OFF_CMD);
  assign wr_par = i_wr && hit(i_addr, OFF_PARAM);

  // ----------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------
  // A busy check at code arrival decides both code and parameter
  assign start_rst  = wr_cmd && !busy && (i_wdata[7:0] == CMD_RESET);
  assign start_slot = wr_par && slot_pend_q && !busy;

  always_comb begin
    o_cmd_ack  = 1'b0;
    o_cmd_nack = 1'b0;
    if (wr_cmd) begin
      if (!busy && (i_wdata[7:0] == CMD_RESET || i_wdata[7:0] == CMD_SLOT)) begin
        o_cmd_ack = 1'b1;
      end else begin
        o_cmd_nack = 1'b1;
      end
    end else if (wr_par) begin
      o_cmd_ack  = start_slot;
      o_cmd_nack = !start_slot;
    end
  end

  // Slot code waits for its parameter; busy at code time leaves nothing pending
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      slot_pend_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_cmd) begin
        slot_pend_q <= !busy && (i_wdata[7:0] == CMD_SLOT);
      end else if (wr_par) begin
        slot_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line input synchroniser
  // ----------------------------------------------------------------
  // A level counts only once the second and third stages agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_q <= 3'h7;
      line_q <= 1'b1;
    end else if (i_ce) begin
      sync_q <= {sync_q[1:0], i_line};
      if (sync_q[1] == sync_q[2]) begin
        line_q <= sync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Line activity begins the cycle after acceptance, well inside 262.5 ns
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q    <= ST_IDLE;
      cnt_q      <= '0;
      slot_val_q <= 1'b0;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= C_ONE;
          if (start_rst) begin
            state_q <= ST_RST_LOW;
          end else if (start_slot) begin
            state_q    <= ST_SLOT_LOW;
            slot_val_q <= i_wdata[SLOT_BIT_POS];
          end
        end
        ST_RST_LOW: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q == C_RST_LOW) begin
            state_q <= ST_RST_HIGH;
          end
        end
        ST_RST_HIGH: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q == C_RST_END) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SLOT_LOW: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q == (slot_val_q ? C_W1_LOW : C_W0_LOW)) begin
            state_q <= ST_SLOT_REC;
          end
        end
        ST_SLOT_REC: begin
          cnt_q <= cnt_q + C_ONE;
          if (cnt_q == C_SLOT) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign finish = (state_q == ST_RST_HIGH && cnt_q == C_RST_END) ||
                  (state_q == ST_SLOT_REC && cnt_q == C_SLOT);

  // Open-drain drive: enable only pulls low, never drives high
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_line_oe <= 1'b0;
    end else if (i_ce) begin
      o_line_oe <= (state_q == ST_IDLE) ? (start_rst || start_slot) :
                   (state_q == ST_RST_LOW && cnt_q != C_RST_LOW) ||
                   (state_q == ST_SLOT_LOW && cnt_q != (slot_val_q ? C_W1_LOW : C_W0_LOW));
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_line_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stat_q <= STATUS_RST;
    end else if (i_ce) begin
      stat_q.line_busy_flag <= busy ? !finish : (start_rst || start_slot);
      if (state_q == ST_RST_HIGH && cnt_q == C_PRES) begin
        stat_q.presence_detected_flag <= !line_q;
      end
      if (state_q == ST_RST_HIGH && cnt_q == C_SHORT) begin
        stat_q.short_detected_flag <= !line_q;
      end
      if ((state_q == ST_SLOT_LOW || state_q == ST_SLOT_REC) && cnt_q == C_SAMPLE) begin
        stat_q.single_bit_result <= line_q;
        stat_q.search_dir        <= line_q;
      end
    end
  end

  assign o_status = stat_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    ev            = EVENTS_RST;
    ev.done       = finish;
    ev.rejected   = o_cmd_nack;
    ev.short_seen = (state_q == ST_RST_HIGH && cnt_q == C_SHORT && !line_q);
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_stat_q <= EVENTS_RST;
    end else if (i_ce) begin
      if (i_wr && hit(i_addr, OFF_IRQ_CLR)) begin
        irq_stat_q <= (irq_stat_q & ~events_t'(i_wdata[2:0])) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_en_q <= EVENTS_RST;
    end else if (i_ce && i_wr && hit(i_addr, OFF_IRQ_EN)) begin
      irq_en_q <= events_t'(i_wdata[2:0]);
    end
  end

  assign o_irq = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // Read pointer and read data
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ptr_q <= PTR_STATUS;
    end else if (i_ce) begin
      if (start_rst || start_slot) begin
        ptr_q <= PTR_STATUS;
      end else if (i_wr && hit(i_addr, OFF_PTR)) begin
        ptr_q <= i_wdata[1:0];
      end
    end
  end

  // Data stand for exactly one cycle after the read strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        if (hit(i_addr, OFF_STATUS)) begin
          o_rdata <= 32'(stat_q);
        end else if (hit(i_addr, OFF_IRQ_STAT)) begin
          o_rdata <= 32'(irq_stat_q);
        end else if (hit(i_addr, OFF_IRQ_EN)) begin
          o_rdata <= 32'(irq_en_q);
        end else if (hit(i_addr, OFF_PTR)) begin
          o_rdata <= 32'(ptr_q);
        end else if (hit(i_addr, OFF_READ)) begin
          if (ptr_q == PTR_IRQ_STAT) begin
            o_rdata <= 32'(irq_stat_q);
          end else if (ptr_q == PTR_IRQ_EN) begin
            o_rdata <= 32'(irq_en_q);
          end else begin
            o_rdata <= 32'(stat_q);
          end
        end
      end
    end
  end

endmodule

/* File: core/swl_pkg.sv */
// Package: constants and carrier types of the single wire reset and bit slot engine
package swl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing (times in ns as specified, counts derived)
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 100;
  localparam int unsigned RESET_LOW_TIME_NS    = 480000;
  localparam int unsigned RESET_HIGH_TIME_NS   = 480000;
  localparam int unsigned PRESENCE_SAMPLE_NS   = 70000;
  localparam int unsigned SHORT_CHECK_TIME_NS  = 8000;
  localparam int unsigned SLOT_TIME_NS         = 70000;
  localparam int unsigned BIT_SAMPLE_TIME_NS   = 15000;
  localparam int unsigned WRITE0_LOW_TIME_NS   = 60000;
  localparam int unsigned WRITE1_LOW_TIME_NS   = 6000;

  // Least times round up to whole cycles
  function automatic int unsigned ns_to_cyc(input int unsigned t_ns);
    ns_to_cyc = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  // ----------------------------------------------------------------
  // Command codes and parameter layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESET  = 8'hB4;
  localparam logic [7:0] CMD_SLOT   = 8'h87;
  localparam int unsigned SLOT_BIT_POS = 7;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_PARAM    = 8'h04;
  localparam logic [7:0] OFF_READ     = 8'h08;
  localparam logic [7:0] OFF_PTR      = 8'h0C;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h1C;

  localparam logic [1:0] PTR_STATUS   = 2'h0;
  localparam logic [1:0] PTR_IRQ_STAT = 2'h1;
  localparam logic [1:0] PTR_IRQ_EN   = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic search_dir;
    logic single_bit_result;
    logic short_detected_flag;
    logic presence_detected_flag;
    logic line_busy_flag;
  } status_t;

  typedef struct packed {
    logic short_seen;
    logic rejected;
    logic done;
  } events_t;

  localparam status_t STATUS_RST = 5'h0_0;
  localparam events_t EVENTS_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RST_LOW  = 3'b001,
    ST_RST_HIGH = 3'b010,
    ST_SLOT_LOW = 3'b011,
    ST_SLOT_REC = 3'b100
  } state_t;

endpackage

/* File: verification/swl_chk.sv */
// Checker: port properties of the reset and bit slot engine
`timescale 1ns/1ps
module swl_chk #(
  parameter int unsigned RST_LOW_CYC  = 40,
  parameter int unsigned RST_HIGH_CYC = 800
) (
  input wire logic                       i_clk,
  input wire logic                       i_rst_n,
  input wire logic                       i_ce,
  input wire logic [swl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0]                i_wdata,
  input wire logic                       i_wr,
  input wire logic                       o_cmd_ack,
  input wire logic                       o_cmd_nack,
  input swl_pkg::status_t                o_status,
  input wire logic                       o_line_o,
  input wire logic                       o_line_oe
);
  import swl_pkg::*;
  // ------------
  // Helper logic
  // ------------
  localparam int RB_LO = RST_LOW_CYC + RST_HIGH_CYC - 1;
  localparam int RB_HI = RST_LOW_CYC + RST_HIGH_CYC + 3;
  localparam int SL_LO = 699;
  localparam int SL_HI = 703;
  logic [15:0] busy_n_q;
  logic [15:0] low_n_q;
  logic        slot_q;
  logic        v_q;
  logic        cmd_wr;
  logic        par_wr;
  logic        busy;
  int          exp_low;
  assign cmd_wr = i_ce && i_wr && i_addr == OFF_CMD;
  assign par_wr = i_ce && i_wr && i_addr == OFF_PARAM;
  assign busy = o_status.line_busy_flag;
  // Low phase width depends on which command launched it
  assign exp_low = !slot_q ? RST_LOW_CYC : v_q ? 60 : 600;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_n_q <= 16'h0000;
      low_n_q <= 16'h0000;
      slot_q <= 1'b0;
      v_q <= 1'b0;
    end else if (i_ce) begin
      busy_n_q <= busy ? busy_n_q + 16'h0001 : 16'h0000;
      low_n_q <= o_line_oe ? low_n_q + 16'h0001 : 16'h0000;
      if (cmd_wr && o_cmd_ack && i_wdata[7:0] == CMD_RESET) slot_q <= 1'b0;
      if (par_wr && o_cmd_ack) begin
        slot_q <= 1'b1;
        v_q <= i_wdata[SLOT_BIT_POS];
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_busy_refuse: assert property (cmd_wr && busy |-> o_cmd_nack && !o_cmd_ack)
    else $error("busy command not refused");
  a_reset_start: assert property (cmd_wr && o_cmd_ack && i_wdata[7:0] == CMD_RESET |=> o_line_oe && busy)
    else $error("reset cycle late");
  a_slot_start: assert property (par_wr && o_cmd_ack |=> o_line_oe && busy)
    else $error("slot late");
  a_busy_len: assert property ($fell(busy) |-> (slot_q ? busy_n_q inside {[SL_LO:SL_HI]}
    : busy_n_q inside {[RB_LO:RB_HI]})) else $error("busy length wrong");
  a_low_width: assert property ($fell(o_line_oe) |-> low_n_q + 2 >= exp_low && low_n_q <= exp_low + 2)
    else $error("low phase width wrong");
  a_idle_quiet: assert property (!busy |-> !o_line_oe && !o_line_o)
    else $error("line driven while idle");
  a_flag_time: assert property ($changed(o_status.presence_detected_flag) ||
    $changed(o_status.short_detected_flag) |-> busy && !slot_q) else $error("reset flags changed outside reset");
  a_bit_time: assert property ($changed(o_status.single_bit_result) |-> busy && slot_q)
    else $error("bit result changed outside slot");
  a_ack_cause: assert property (o_cmd_ack || o_cmd_nack |-> i_wr && !(o_cmd_ack && o_cmd_nack)
    && (i_addr == OFF_CMD || i_addr == OFF_PARAM)) else $error("stray answer");
  cover property (cmd_wr && o_cmd_ack && i_wdata[7:0] == CMD_RESET);
  cover property (par_wr && o_cmd_ack);
  cover property (cmd_wr && o_cmd_nack);
endmodule

/* File: verification/swl_slave.sv */
// Partner: behavioural slave devices on the wire
`timescale 1ns/1ps
module swl_slave (
  input  wire logic       i_clk,
  input  wire logic       i_line_oe,
  input  wire logic [1:0] i_mode,
  output logic            o_pull
);
  // ------------------------------------------------------
  // Modes: 0 quiet, 1 presence, 2 shorted, 3 answers zero
  // ------------------------------------------------------
  int unsigned rel_n = 5000;
  int unsigned low_n = 5000;
  logic        oe_q  = 1'b0;
  always_ff @(posedge i_clk) begin
    oe_q <= i_line_oe;
    rel_n <= i_line_oe ? 0 : rel_n + 1;
    low_n <= (i_line_oe && !oe_q) ? 0 : low_n + 1;
  end
  // Presence window straddles the sample instant with wide margin both sides
  always_comb begin
    case (i_mode)
      2'h1: o_pull = !i_line_oe && rel_n >= 200 && rel_n < 900;
      2'h2: o_pull = 1'b1;
      2'h3: o_pull = low_n < 300;
      default: o_pull = 1'b0;
    endcase
  end
endmodule

/* File: verification/tb_single_wire_reset_and_bit_slot.sv */
// Testbench: register level tests of the reset and bit slot engine
`timescale 1ns/1ps
module tb_single_wire_reset_and_bit_slot;
  import swl_pkg::*;
  // -----
  // Setup
  // -----
  localparam int unsigned LOW = 40;
  localparam int unsigned HIGH = 800;
  logic        i_clk = 0, i_rst_n = 0, i_ce = 1, i_wr = 0, i_rd = 0, oe, lo, ack, nack, irq, pull;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000, rdata, rv, r;
  logic [1:0]  mode = 2'h0;
  status_t     st;
  logic [31:0] seed = 32'h0000_0033;
  int          mismatches = 0, checks_done = 0, cyc = 0;
  single_wire_reset_and_bit_slot #(.RST_LOW_CYC(LOW), .RST_HIGH_CYC(HIGH)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_cmd_ack(ack),
    .o_cmd_nack(nack), .o_irq(irq), .o_status(st), .i_line(!(oe || pull)), .o_line_o(lo), .o_line_oe(oe));
  swl_slave u_slave (.i_clk(i_clk), .i_line_oe(oe), .i_mode(mode), .o_pull(pull));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Shorted line or an answering slave reads as zero
  function automatic logic exp_bit(input logic v, input logic [1:0] m);
    return v && m != 2'h3 && m != 2'h2;
  endfunction
  task automatic test_done();
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(negedge i_clk);
    chk("answer", {30'h0, e}, {30'h0, ack, nack});
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    rv = rdata;
  endtask
  // Pointer rests on status after a command, so the read port polls busy
  task automatic wait_idle();
    int n;
    n = 0;
    rd(OFF_READ);
    while (rv[0] !== 1'b0 && n < 2000) begin
      rd(OFF_READ);
      n++;
    end
    if (n == 2000) chk("busy", 32'h0000_0000, 32'h0000_0001);
  endtask
  // ---------
  // Scenarios
  // ---------
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(OFF_STATUS);
    chk("status", 32'h0000_0000, rv);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    for (int m = 0; m < 3; m++) begin
      mode <= m[1:0];
      wr(OFF_IRQ_EN, (m == 0) ? 32'h0000_0000 : 32'h0000_0007, 2'h0);
      wr(OFF_CMD, {24'h0, CMD_RESET}, 2'h2);
      wr(OFF_CMD, {24'h0, CMD_RESET}, 2'h1);
      wr(OFF_CMD, {24'h0, CMD_SLOT}, 2'h1);
      wr(OFF_PARAM, 32'h0000_0080, 2'h1);
      wait_idle();
      chk("presence", {31'h0, m != 0}, {31'h0, st.presence_detected_flag});
      chk("short", {31'h0, m == 2}, {31'h0, st.short_detected_flag});
      rd(OFF_IRQ_STAT);
      chk("irq_stat", {29'h0, m == 2, 2'h3}, rv);
      chk("irq", {31'h0, m != 0}, {31'h0, irq});
      wr(OFF_IRQ_CLR, 32'h0000_0007, 2'h0);
      rd(OFF_IRQ_STAT);
      chk("irq_clr", 32'h0000_0000, {rv[31:1], irq});
    end
    rd(OFF_IRQ_EN);
    chk("irq_en", 32'h0000_0007, rv);
    wr(OFF_PTR, 32'h0000_0002, 2'h0);
    rd(OFF_PTR);
    chk("ptr", 32'h0000_0002, rv);
    rd(OFF_READ);
    chk("read_en", 32'h0000_0007, rv);
    for (int k = 0; k < 4; k++) begin
      mode <= k[1] ? 2'h3 : 2'h0;
      r = xs();
      wr(OFF_PTR, 32'h0000_0001, 2'h0);
      wr(OFF_CMD, {24'h0, CMD_SLOT}, 2'h2);
      wr(OFF_PARAM, {r[31:8], k[0], r[6:0]}, 2'h2);
      rd(OFF_READ);
      chk("read_ptr", 32'h0000_0001, {31'h0, rv[0]});
      wait_idle();
      chk("bit", {31'h0, exp_bit(k[0], mode)}, {31'h0, st.single_bit_result});
      chk("dir", {31'h0, exp_bit(k[0], mode)}, {31'h0, st.search_dir});
    end
    for (int k = 0; k < 8; k++) begin
      r = xs();
      if (r[7:0] == CMD_RESET || r[7:0] == CMD_SLOT) r[7:0] = 8'h00;
      wr(OFF_CMD, r, 2'h1);
    end
    wr(OFF_PARAM, 32'h0000_0080, 2'h1);
    wr(8'h20, r, 2'h0);
    rd(8'h20);
    chk("unmapped", 32'h0000_0000, rv);
    mode <= 2'h1;
    wr(OFF_CMD, {24'h0, CMD_RESET}, 2'h2);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk("abort", 32'h0000_0000, {26'h0, st, oe});
    wr(OFF_CMD, {24'h0, CMD_RESET}, 2'h2);
    // Frozen longer than the low phase: a live sequencer would release the line
    i_ce <= 1'b0;
    repeat (50) @(posedge i_clk);
    @(negedge i_clk);
    chk("freeze", 32'h0000_0003, {26'h0, st, oe});
    @(posedge i_clk);
    i_ce <= 1'b1;
    wait_idle();
    chk("presence", 32'h0000_0001, {31'h0, st.presence_detected_flag});
    test_done();
  end
endmodule
bind single_wire_reset_and_bit_slot swl_chk #(.RST_LOW_CYC(RST_LOW_CYC), .RST_HIGH_CYC(RST_HIGH_CYC)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .o_cmd_ack(o_cmd_ack), .o_cmd_nack(o_cmd_nack), .o_status(o_status), .o_line_o(o_line_o), .o_line_oe(o_line_oe));
